//--- inc/tsb_pkg.sv
// package for the trace sync barrier control block
package tsb_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] TSB_OFF_CTRL   = 12'h000;
    localparam logic [11:0] TSB_OFF_STATUS = 12'h004;
    localparam logic [11:0] TSB_OFF_OUTST  = 12'h008;
    localparam logic [11:0] TSB_OFF_FLT    = 12'h00C;
    localparam logic [11:0] TSB_OFF_TIMEOUT = 12'h010;
    // ctrl field positions
    localparam int TSB_CTRL_UNIT_EN  = 0;
    localparam int TSB_CTRL_OS_LOCK  = 1;
    localparam int TSB_CTRL_FLUSH_TRG = 2;
    // filter field positions
    localparam int TSB_FLT_USER    = 0;
    localparam int TSB_FLT_KERNEL  = 1;
    localparam int TSB_FLT_HYP     = 2;
    localparam int TSB_FLT_HUSER   = 3;
    localparam logic [31:0] TSB_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TSB_FLT_RST  = 32'h0000_0000;
    // ------------------------------------------------------------
    // timing: finite-time guarantee on op drain
    // ------------------------------------------------------------
    localparam int TSB_CLK_NS       = 100;
    localparam int TSB_DRAIN_MAX_US = 100;
    localparam int TSB_DRAIN_CYC    = TSB_DRAIN_MAX_US * 1000 / TSB_CLK_NS;
    localparam int TSB_CNT_W        = 8;
    // access classes of trace-unit register accesses
    typedef enum logic [1:0] {
        TSB_CLS_INSTR = 2'h0,
        TSB_CLS_OP    = 2'h1,
        TSB_CLS_OTHER = 2'h2
    } tsb_cls_t;
    // exception level of a retiring instruction
    typedef enum logic [1:0] {
        TSB_EL_USER = 2'h0,
        TSB_EL_KERN = 2'h1,
        TSB_EL_HYP  = 2'h2
    } tsb_el_t;
    // retiring instruction descriptor
    typedef struct packed {
        logic    valid;
        logic    speculative;
        logic    is_barrier;
        logic    is_csync;
        logic    is_reg_wr;
        logic    hosted;
        tsb_el_t el;
    } tsb_instr_t;
    // trace operation event, written toward the trace unit
    typedef struct packed {
        logic             valid;
        logic             speculative;
        logic [TSB_CNT_W-1:0] tag;
    } tsb_op_t;
    // quiescence/progress reports from trace unit and buffer writer
    typedef struct packed {
        logic op_done;
        logic op_reg_done;
        logic mgmt_done;
        logic abort_upd;
        logic unit_op;
        logic unit_op_done;
        logic flush_done;
        logic flush_wr_done;
        logic unit_quiet;
        logic writer_quiet;
        logic mem_done;
    } tsb_rpt_t;
endpackage

//--- logic/tsb_ctrl.sv
// trace sync barrier control: op generation, completion and barrier hold
//
// Contract
// - each executed instruction decides on a trace op producing flow trace
// - filter enable reads for prohibited region belong to the instruction
// - unit enable and os lock status also read per instruction
// - every trace-unit register access carries a class: instr, op or other
// - buffer writer register accesses tied to the causing trace op
// - buffer writer writes are coherent within the access shareability domain
// - common domain of core and writer is the non-shareable domain
// - ops, memory writes and endpoint arrival finish in finite time
// - op register updates visible only after an explicit trace sync
// - op not finished until all its register reads and writes done
// - flush-raising op waits for flush, accepted ops and flush writes
// - finishing includes memory-write and management-event register updates
// - abort-response register updates excluded from finishing
// - op complete once finished, memory done, abort updates done
// - prohibited-region barrier waits for ops older than the context sync
// - barrier also waits for speculative ops not after the context sync
// - barrier also waits for unit-generated ops
// - unit goes quiet before barrier ends, stays quiet while prohibited
// - flush begun before barrier end completes before barrier ends
// - executing the barrier produces a trace sync event
//
// The implementer's own choices: the register addresses and the APB register port.
module tsb_ctrl
    import tsb_pkg::*;
#(
    parameter int DRAIN_CYC = TSB_DRAIN_CYC
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pipeline side
    input  wire tsb_pkg::tsb_instr_t instr,
    input  wire logic        debug_state,
    output logic             retire_hold,
    output logic             reg_wr_hold,
    // trace unit / buffer writer side
    output tsb_pkg::tsb_op_t op_out,
    output tsb_pkg::tsb_cls_t op_cls,
    output logic             sync_event,
    output logic             unit_pause,
    output logic             non_shareable,
    input  wire tsb_pkg::tsb_rpt_t rpt,
    input  wire logic        flush_start
);
    import tsb_pkg::*;

    typedef enum logic [1:0] {
        TSB_IDLE,
        TSB_WAIT,
        TSB_RELEASE
    } tsb_state_t;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]          ctrl_r;
    logic [31:0]          flt_r;
    logic [TSB_CNT_W-1:0] old_r;
    logic [TSB_CNT_W-1:0] young_r;
    logic [TSB_CNT_W-1:0] unit_r;
    logic [TSB_CNT_W-1:0] cmpl_r;
    logic [TSB_CNT_W-1:0] tag_r;
    logic                 flush_r;
    logic                 flush_wr_r;
    logic                 prohib_r;
    logic                 sync_done_r;
    logic                 timeout_r;
    logic [31:0]          drain_r;
    tsb_state_t           state_r;

    // saturating step of an outstanding counter; saturation keeps a stray
    // completion from wrapping a count at zero round to a false all-ones
    function automatic logic [TSB_CNT_W-1:0] step(
        input logic [TSB_CNT_W-1:0] v,
        input logic                 inc,
        input logic                 dec
    );
        logic [TSB_CNT_W-1:0] r;
        r = v;
        if (inc && !dec && v != {TSB_CNT_W{1'b1}}) begin
            r = v + 1'b1;
        end else if (dec && !inc && v != '0) begin
            r = v - 1'b1;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // per-instruction trace decision
    // ------------------------------------------------------------
    logic allow;
    logic gen_op;
    logic wr_acc;
    logic rd_acc;
    logic op_fin;
    logic barrier_go;
    logic drained;

    always_comb begin
        // filter bits read on behalf of this instruction
        // hosted user level has its own enable bit
        case (instr.el)
            TSB_EL_USER: allow = instr.hosted ? flt_r[TSB_FLT_HUSER]
                                             : flt_r[TSB_FLT_USER];
            TSB_EL_KERN: allow = flt_r[TSB_FLT_KERNEL];
            TSB_EL_HYP:  allow = flt_r[TSB_FLT_HYP];
            default:     allow = 1'b0;
        endcase
    end

    // unit enable and os lock join the decision; paused unit emits nothing
    assign gen_op = instr.valid && allow && ctrl_r[TSB_CTRL_UNIT_EN] &&
                    !ctrl_r[TSB_CTRL_OS_LOCK] && !unit_pause;

    // finished needs register access done and management updates done;
    // abort-response updates deliberately do not gate it
    assign op_fin = rpt.op_done && rpt.op_reg_done &&
                    rpt.mgmt_done;

    assign barrier_go = instr.valid && instr.is_barrier && !debug_state &&
                        prohib_r && state_r == TSB_IDLE;

    // flush in flight keeps the barrier and flush op open; a flush that
    // starts in the very cycle the counters empty must still be waited for
    assign drained = old_r == '0 && young_r == '0 &&
                     unit_r == '0 &&
                     !flush_r && !flush_wr_r && !flush_start &&
                     !ctrl_r[TSB_CTRL_FLUSH_TRG] &&
                     rpt.unit_quiet && rpt.writer_quiet;

    // ------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------
    // a write lands only on the access edge, where pready is seen high
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;

    // ------------------------------------------------------------
    // apb slave: zero-wait access, reads registered in setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            // unmapped offsets answer with an error and are never written
            pslverr <= psel && !penable &&
                       !(paddr == TSB_OFF_CTRL || paddr == TSB_OFF_STATUS ||
                         paddr == TSB_OFF_OUTST || paddr == TSB_OFF_FLT ||
                         paddr == TSB_OFF_TIMEOUT);
            if (rd_acc) begin
                case (paddr)
                    TSB_OFF_CTRL:   prdata <= ctrl_r;
                    TSB_OFF_STATUS: prdata <= {26'h0, timeout_r, sync_done_r,
                                               prohib_r, flush_r,
                                               unit_pause, retire_hold};
                    TSB_OFF_OUTST:  prdata <= {cmpl_r, unit_r, young_r, old_r};
                    TSB_OFF_FLT:    prdata <= flt_r;
                    TSB_OFF_TIMEOUT: prdata <= drain_r;
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // only byte lane 0 holds state; upper bits always read back zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= TSB_CTRL_RST;
            flt_r  <= TSB_FLT_RST;
        end else if (clk_en) begin
            ctrl_r[TSB_CTRL_FLUSH_TRG] <= 1'b0;
            if (wr_acc && pready && paddr == TSB_OFF_CTRL && pstrb[0]) begin
                ctrl_r[7:0] <= pwdata[7:0];
            end
            if (wr_acc && pready && paddr == TSB_OFF_FLT && pstrb[0]) begin
                flt_r[7:0] <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // outstanding trace ops
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_out  <= '0;
            op_cls  <= TSB_CLS_INSTR;
            tag_r   <= '0;
            old_r   <= '0;
            young_r <= '0;
            unit_r  <= '0;
            cmpl_r  <= '0;
        end else if (clk_en) begin
            op_out.valid       <= gen_op;
            op_out.speculative <= instr.speculative;
            op_out.tag         <= tag_r;
            // tells the trace unit on whose behalf this cycle's reads count
            op_cls <= gen_op ? TSB_CLS_OP :
                      (instr.valid ? TSB_CLS_INSTR : TSB_CLS_OTHER);
            if (gen_op) begin
                tag_r <= tag_r + 1'b1;
            end
            // a context sync ages every younger op into the older set
            if (instr.valid && instr.is_csync) begin
                // an op finishing in this same cycle still leaves the set
                old_r   <= old_r + young_r
                           + {{(TSB_CNT_W-1){1'b0}}, gen_op}
                           - {{(TSB_CNT_W-1){1'b0}}, op_fin};
                young_r <= '0;
            end else begin
                young_r <= step(young_r, gen_op, op_fin && old_r == '0);
                old_r   <= step(old_r, 1'b0, op_fin);
            end
            unit_r <= step(unit_r, rpt.unit_op && !unit_pause,
                           rpt.unit_op_done);
            // complete needs memory and abort updates on top of finishing
            cmpl_r <= step(cmpl_r, op_fin,
                           rpt.mem_done && rpt.abort_upd);
        end
    end

    // ------------------------------------------------------------
    // flush tracking: set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_r    <= 1'b0;
            flush_wr_r <= 1'b0;
        end else if (clk_en) begin
            if (flush_start || ctrl_r[TSB_CTRL_FLUSH_TRG]) begin
                flush_r <= 1'b1;
            end else if (rpt.flush_done) begin
                flush_r <= 1'b0;
            end
            // writes made at flush end are tracked apart, so the barrier
            // also waits for them after the flush itself reports done
            if (flush_r && rpt.flush_done) begin
                flush_wr_r <= 1'b1;
            end else if (rpt.flush_wr_done) begin
                flush_wr_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // prohibited region and barrier sequencing
    // ------------------------------------------------------------
    // region is fixed at each context sync; filter writes in between do
    // not move it, so a barrier always sees one stable answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prohib_r <= 1'b0;
        end else if (clk_en && instr.valid && instr.is_csync) begin
            prohib_r <= !allow;
        end
    end

    // ------------------------------------------------------------
    // barrier state machine
    // ------------------------------------------------------------
    // timeout only raises a status flag: releasing early would let a
    // direct write overtake register accesses of older ops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= TSB_IDLE;
            retire_hold <= 1'b0;
            sync_event  <= 1'b0;
            sync_done_r <= 1'b0;
            timeout_r   <= 1'b0;
            drain_r     <= 32'h0000_0000;
            unit_pause  <= 1'b0;
            reg_wr_hold <= 1'b0;
        end else if (clk_en) begin
            // every barrier marks a sync event, held or not
            sync_event <= instr.valid && instr.is_barrier;
            if (!prohib_r) begin
                unit_pause  <= 1'b0;
                sync_done_r <= 1'b0;
            end
            case (state_r)
                TSB_IDLE: begin
                    if (barrier_go) begin
                        state_r     <= TSB_WAIT;
                        retire_hold <= 1'b1;
                        reg_wr_hold <= 1'b1;
                        unit_pause  <= 1'b1;
                        drain_r     <= 32'h0000_0000;
                    end
                end
                TSB_WAIT: begin
                    drain_r <= drain_r + 32'h0000_0001;
                    // a wait past DRAIN_CYC cycles only sets timeout_r; the hold stays until drained
                    if (drain_r >= 32'(DRAIN_CYC)) begin
                        timeout_r <= 1'b1;
                    end
                    if (drained) begin
                        state_r <= TSB_RELEASE;
                    end
                end
                TSB_RELEASE: begin
                    retire_hold <= 1'b0;
                    reg_wr_hold <= 1'b0;
                    sync_done_r <= 1'b1;
                    state_r     <= TSB_IDLE;
                end
                default: state_r <= TSB_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // coherence domain
    // ------------------------------------------------------------
    // writer shares only the non-shareable domain with the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            non_shareable <= 1'b1;
        end else if (clk_en) begin
            non_shareable <= 1'b1;
        end
    end
endmodule

//--- tb/tsb_ctrl_properties.sv
// checker of barrier, op and pause relations at the controller ports
module tsb_ctrl_properties
    import tsb_pkg::*;
(
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // pipeline and partner inputs
    input wire tsb_pkg::tsb_instr_t instr,
    input wire logic              debug_state,
    input wire logic              flush_start,
    input wire tsb_pkg::tsb_rpt_t rpt,
    // controller outputs
    input wire tsb_pkg::tsb_op_t  op_out,
    input wire tsb_pkg::tsb_cls_t op_cls,
    input wire logic              retire_hold,
    input wire logic              unit_pause,
    input wire logic              sync_event,
    input wire logic              non_shareable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence barrier_s;
        instr.valid && instr.is_barrier;
    endsequence
    sequence drained_s;
        rpt.unit_quiet && rpt.writer_quiet;
    endsequence
    a_sync_after_barrier: assert property (barrier_s |=> sync_event)
        else $error("barrier gave no sync event");
    a_op_has_cause: assert property (
        op_out.valid |-> $past(instr.valid))
        else $error("op without an instruction");
    a_paused_no_op: assert property (
        unit_pause && $past(unit_pause) |-> !op_out.valid)
        else $error("op issued while paused");
    a_hold_implies_pause: assert property (retire_hold |-> unit_pause)
        else $error("hold without pause");
    a_release_when_quiet: assert property (
        $fell(retire_hold) |-> $past(rpt.unit_quiet && rpt.writer_quiet, 2))
        else $error("released while not quiet");
    a_busy_keeps_hold: assert property (
        retire_hold && !$past(rpt.unit_quiet) |=> retire_hold)
        else $error("released while unit busy");
    a_flush_keeps_hold: assert property (
        retire_hold && flush_start |=> retire_hold [*2])
        else $error("released during flush");
    a_debug_no_hold: assert property (
        barrier_s ##0 debug_state && !retire_hold |=> !retire_hold)
        else $error("barrier held in debug state");
    a_domain_fixed: assert property (non_shareable)
        else $error("domain not non-shareable");
    a_class_legal: assert property (op_cls != 2'h3)
        else $error("illegal access class");
    c_drained: cover property (retire_hold ##1 drained_s);
endmodule

//--- tb/tsb_partner.sv
// behavioural trace unit and buffer writer facing the controller
module tsb_partner
    import tsb_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // from controller and bench
    input  wire tsb_pkg::tsb_op_t  op_out,
    input  wire logic [7:0]        lat,
    input  wire logic              unit_req,
    input  wire logic              flush_req,
    // reports
    output tsb_pkg::tsb_rpt_t      rpt,
    output logic                   flush_start
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pend_r;
    logic [7:0] tmr_r;
    logic       unit_r;
    logic       fl_r;
    logic       fw_r;
    logic       busy;
    logic       fire;
    logic       op_fin;
    assign busy   = pend_r != 8'h00 || unit_r || fl_r;
    assign fire   = busy && tmr_r == 8'h00;
    assign op_fin = fire && !fl_r && !unit_r;
    // one completion per lat+1 cycles: flush first, then unit op, then ops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_r       <= 8'h00;
            pend_r      <= 8'h00;
            unit_r      <= 1'b0;
            fl_r        <= 1'b0;
            fw_r        <= 1'b0;
            flush_start <= 1'b0;
        end else begin
            tmr_r       <= (fire || !busy) ? lat : tmr_r - 8'h01;
            pend_r      <= pend_r + {7'h00, op_out.valid} - {7'h00, op_fin};
            unit_r      <= unit_req || (unit_r && !(fire && !fl_r));
            fl_r        <= flush_start || (fl_r && !fire);
            // flush-end writes report one cycle after the flush itself
            fw_r        <= fire && fl_r;
            flush_start <= flush_req;
        end
    end
    always_comb begin
        rpt               = '0;
        rpt.op_done       = op_fin;
        rpt.op_reg_done   = op_fin;
        rpt.mgmt_done     = op_fin;
        rpt.mem_done      = op_fin;
        // writes never abort here, so abort updates are done at finish
        rpt.abort_upd     = op_fin;
        rpt.unit_op       = unit_req;
        rpt.unit_op_done  = fire && !fl_r && unit_r;
        rpt.flush_done    = fire && fl_r;
        rpt.flush_wr_done = fw_r;
        rpt.unit_quiet    = !busy;
        rpt.writer_quiet  = pend_r == 8'h00;
    end
endmodule

//--- tb/tsb_testbench.sv
// self-checking bench for the trace sync barrier controller
module testbench;
    import tsb_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic retire_hold, reg_wr_hold, sync_event, unit_pause, non_shareable;
    logic debug_state, flush_start, unit_req, flush_req;
    logic [7:0] lat;
    tsb_instr_t instr;
    tsb_op_t op_out;
    tsb_cls_t op_cls;
    tsb_rpt_t rpt;
    int err_total, checks_done;
    logic [1:0] ctl[6] = '{2'h1, 2'h3, 2'h0, 2'h1, 2'h1, 2'h1};
    logic [3:0] flt[6] = '{4'hF, 4'hF, 4'hF, 4'hE, 4'hE, 4'hB};
    tsb_el_t lvl[6] = '{TSB_EL_USER, TSB_EL_USER, TSB_EL_KERN,
                        TSB_EL_USER, TSB_EL_KERN, TSB_EL_HYP};
    logic exp_op[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    tsb_ctrl #(.DRAIN_CYC(20)) uut (.pclk(pclk), .presetn(presetn),
        .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr(instr),
        .debug_state(debug_state), .retire_hold(retire_hold),
        .reg_wr_hold(reg_wr_hold), .op_out(op_out), .op_cls(op_cls),
        .sync_event(sync_event), .unit_pause(unit_pause),
        .non_shareable(non_shareable), .rpt(rpt), .flush_start(flush_start));
    tsb_partner far (.pclk(pclk), .presetn(presetn), .op_out(op_out),
        .lat(lat), .unit_req(unit_req), .flush_req(flush_req), .rpt(rpt),
        .flush_start(flush_start));
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkb(input string what, input logic exp, got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask
    // one apb transfer; read data checked against d
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        if (!pready) begin
            err_total++;
            summarize();
        end
        chkb("pslverr", err, pslverr);
        if (!wr) chk("prdata", d, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run(input logic bar, csy, input tsb_el_t el,
                       input logic op, sy);
        instr <= {1'b1, 1'b0, bar, csy, 1'b0, 1'b0, el};
        @(posedge pclk);
        instr <= '0;
        @(negedge pclk);
        chkb("op_out.valid", op, op_out.valid);
        chkb("sync_event", sy, sync_event);
        chk("op_cls", {30'h0, (op ? TSB_CLS_OP : TSB_CLS_INSTR)},
            {30'h0, op_cls});
        @(posedge pclk);
    endtask
    task automatic wait_rel;
        int n;
        n = 0;
        while (retire_hold && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (retire_hold) begin
            err_total++;
            summarize();
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, debug_state} = '0;
        {unit_req, flush_req, paddr, pwdata, instr} = '0;
        {err_total, checks_done} = '0;
        lat = 8'h02;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chkb("non_shareable", 1'b1, non_shareable);
        apb(1'b0, TSB_OFF_CTRL, TSB_CTRL_RST, 1'b0);
        apb(1'b0, TSB_OFF_FLT, TSB_FLT_RST, 1'b0);
        apb(1'b0, 12'h020, 32'h0, 1'b1);
        apb(1'b1, TSB_OFF_FLT, 32'h0000_050A, 1'b0);
        apb(1'b0, TSB_OFF_FLT, 32'h0000_000A, 1'b0);
        // enable, os lock and filter decide op generation per instruction
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, TSB_OFF_CTRL, {30'h0, ctl[k]}, 1'b0);
            apb(1'b1, TSB_OFF_FLT, {28'h0, flt[k]}, 1'b0);
            run(1'b0, 1'b0, lvl[k], exp_op[k], 1'b0);
        end
        apb(1'b1, TSB_OFF_FLT, 32'h0000_000E, 1'b0);
        run(1'b0, 1'b1, TSB_EL_USER, 1'b0, 1'b0);
        debug_state <= 1'b1;
        run(1'b1, 1'b0, TSB_EL_USER, 1'b0, 1'b1);
        chkb("retire_hold", 1'b0, retire_hold);
        debug_state <= 1'b0;
        lat <= 8'h0C;
        run(1'b0, 1'b0, TSB_EL_KERN, 1'b1, 1'b0);
        unit_req <= 1'b1;
        @(posedge pclk);
        unit_req <= 1'b0;
        run(1'b0, 1'b1, TSB_EL_USER, 1'b0, 1'b0);
        run(1'b1, 1'b0, TSB_EL_USER, 1'b0, 1'b1);
        flush_req <= 1'b1;
        @(posedge pclk);
        flush_req <= 1'b0;
        repeat (3) @(posedge pclk);
        chkb("retire_hold", 1'b1, retire_hold);
        chkb("reg_wr_hold", 1'b1, reg_wr_hold);
        chkb("unit_pause", 1'b1, unit_pause);
        wait_rel();
        @(negedge pclk);
        chkb("unit_quiet", 1'b1, rpt.unit_quiet);
        @(posedge pclk);
        chkb("unit_pause", 1'b1, unit_pause);
        chkb("reg_wr_hold", 1'b0, reg_wr_hold);
        run(1'b0, 1'b0, TSB_EL_KERN, 1'b0, 1'b0);
        apb(1'b0, TSB_OFF_OUTST, 32'h0000_0000, 1'b0);
        summarize();
    end
endmodule
bind tsb_ctrl tsb_ctrl_properties u_chk (.pclk(pclk), .presetn(presetn),
    .instr(instr), .debug_state(debug_state), .flush_start(flush_start),
    .rpt(rpt), .op_out(op_out), .op_cls(op_cls), .retire_hold(retire_hold),
    .unit_pause(unit_pause), .sync_event(sync_event),
    .non_shareable(non_shareable));
